// *** verilog/alt_threshold_regs.sv ***
// Purpose: Low and noise threshold registers and per-controller level compare
// Assumes: Configuration port and levels are synchronous to i_clk_sys
// Notes:   High fields come from the neighbouring register bank
`timescale 1ns/1ps
`default_nettype none
module alt_threshold_regs
    import alt_pkg::*;
(
    // Clock, reset, enable
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_rst,
    input  wire logic                   i_ce,
    // Configuration port
    input  wire logic                   i_wr_en,
    input  wire logic                   i_rd_en,
    input  wire logic [ALT_ADDR_W-1:0]  i_addr,
    input  wire logic [ALT_DATA_W-1:0]  i_wr_data,
    output logic      [ALT_DATA_W-1:0]  o_rd_data,
    output logic                        o_rd_valid,
    // High thresholds from neighbouring bank
    input  wire logic [ALT_FIELD_W-1:0] i_satellite_high_level_field,
    input  wire logic [ALT_FIELD_W-1:0] i_mono_high_level_field,
    // Measured average levels, dB below full scale
    input  wire logic [ALT_LEVEL_W-1:0] i_sat1_level,
    input  wire logic [ALT_LEVEL_W-1:0] i_sat2_level,
    input  wire logic [ALT_LEVEL_W-1:0] i_mono_level,
    // Per-controller decisions, index by alt_ctrl_t
    output logic      [ALT_NUM_CTRL-1:0] o_gain_down,
    output logic      [ALT_NUM_CTRL-1:0] o_below_low,
    output logic      [ALT_NUM_CTRL-1:0] o_below_noise,
    // Ordering check per group
    output logic                        o_sat_order_bad,
    output logic                        o_mono_order_bad
);
    logic [ALT_FIELD_W-1:0] satellite_low_level_field_reg;
    logic [ALT_FIELD_W-1:0] satellite_noise_level_field_reg;
    logic [ALT_FIELD_W-1:0] mono_low_level_field_reg;
    logic [ALT_FIELD_W-1:0] mono_noise_level_field_reg;
    logic [ALT_DATA_W-1:0]  rd_data_next;
    logic [ALT_NUM_CTRL-1:0] above_w;
    logic [ALT_NUM_CTRL-1:0] low_w;
    logic [ALT_NUM_CTRL-1:0] noise_w;

    function automatic logic alt_hit(input logic [ALT_ADDR_W-1:0] a,
                                     input logic [ALT_ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction

    // Field writes; bit 7 is dropped so it stays zero
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            satellite_low_level_field_reg   <= ALT_FIELD_RST;
            satellite_noise_level_field_reg <= ALT_FIELD_RST;
            mono_low_level_field_reg        <= ALT_FIELD_RST;
            mono_noise_level_field_reg      <= ALT_FIELD_RST;
        end else if (i_ce && i_wr_en) begin
            if (alt_hit(i_addr, ALT_SAT_LOW_OFS)) begin
                satellite_low_level_field_reg <= i_wr_data[ALT_FIELD_W-1:0];
            end
            if (alt_hit(i_addr, ALT_SAT_NOISE_OFS)) begin
                satellite_noise_level_field_reg <= i_wr_data[ALT_FIELD_W-1:0];
            end
            if (alt_hit(i_addr, ALT_MONO_LOW_OFS)) begin
                mono_low_level_field_reg <= i_wr_data[ALT_FIELD_W-1:0];
            end
            if (alt_hit(i_addr, ALT_MONO_NOISE_OFS)) begin
                mono_noise_level_field_reg <= i_wr_data[ALT_FIELD_W-1:0];
            end
        end
    end

    // Read mux; unmapped offsets answer zero
    always_comb begin
        rd_data_next = ALT_RDATA_RST;
        if (alt_hit(i_addr, ALT_SAT_LOW_OFS)) begin
            rd_data_next = {1'b0, satellite_low_level_field_reg};
        end else if (alt_hit(i_addr, ALT_SAT_NOISE_OFS)) begin
            rd_data_next = {1'b0, satellite_noise_level_field_reg};
        end else if (alt_hit(i_addr, ALT_MONO_LOW_OFS)) begin
            rd_data_next = {1'b0, mono_low_level_field_reg};
        end else if (alt_hit(i_addr, ALT_MONO_NOISE_OFS)) begin
            rd_data_next = {1'b0, mono_noise_level_field_reg};
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_rd_data  <= ALT_RDATA_RST;
            o_rd_valid <= 1'b0;
        end else if (i_ce) begin
            o_rd_valid <= i_rd_en;
            if (i_rd_en) begin
                o_rd_data <= rd_data_next;
            end
        end
    end

    // One comparator per controller; both satellites see one threshold set
    genvar g;
    generate
        for (g = 0; g < ALT_NUM_CTRL; g++) begin : g_ctrl
            alt_thr_if t ();
            if (g == int'(ALT_CTRL_MONO)) begin : g_mono
                assign t.high_field  = i_mono_high_level_field;
                assign t.low_field   = mono_low_level_field_reg;
                assign t.noise_field = mono_noise_level_field_reg;
                assign t.level       = i_mono_level;
            end else begin : g_sat
                assign t.high_field  = i_satellite_high_level_field;
                assign t.low_field   = satellite_low_level_field_reg;
                assign t.noise_field = satellite_noise_level_field_reg;
                assign t.level       = (g == int'(ALT_CTRL_SAT1)) ? i_sat1_level
                                                                  : i_sat2_level;
            end
            alt_level_compare u_cmp (
                .t (t.cmp)
            );
            assign above_w[g] = t.above_high;
            assign low_w[g]   = t.below_low;
            assign noise_w[g] = t.below_noise;
        end
    endgenerate

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_gain_down   <= '0;
            o_below_low   <= '0;
            o_below_noise <= '0;
        end else if (i_ce) begin
            o_gain_down   <= above_w;
            o_below_low   <= low_w;
            o_below_noise <= noise_w;
        end
    end

    // Larger field means quieter, so noise must be >= low >= high numerically
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_sat_order_bad  <= 1'b0;
            o_mono_order_bad <= 1'b0;
        end else if (i_ce) begin
            o_sat_order_bad  <= (satellite_noise_level_field_reg < satellite_low_level_field_reg)
                             || (satellite_low_level_field_reg < i_satellite_high_level_field);
            o_mono_order_bad <= (mono_noise_level_field_reg < mono_low_level_field_reg)
                             || (mono_low_level_field_reg < i_mono_high_level_field);
        end
    end
endmodule // alt_threshold_regs
`default_nettype wire

// *** verilog/alt_pkg.sv ***
// Purpose: Constants for the gain-control level threshold register bank
// Assumes: 8-bit configuration port, byte-wide registers
// Notes:   Field values are dB below full scale in 2 dB steps
package alt_pkg;
    localparam int          ALT_ADDR_W      = 8;
    localparam int          ALT_DATA_W      = 8;
    localparam int          ALT_FIELD_W     = 7;
    localparam int          ALT_LEVEL_W     = 8;
    localparam int          ALT_NUM_CTRL    = 3;

    // Register offsets
    localparam logic [7:0]  ALT_SAT_LOW_OFS   = 8'h18;
    localparam logic [7:0]  ALT_SAT_NOISE_OFS = 8'h19;
    localparam logic [7:0]  ALT_MONO_LOW_OFS  = 8'h20;
    localparam logic [7:0]  ALT_MONO_NOISE_OFS = 8'h21;

    // Field layout and reset values
    localparam int          ALT_RSVD_BIT    = 7;
    localparam logic [6:0]  ALT_FIELD_RST   = 7'h00;
    localparam logic [7:0]  ALT_RDATA_RST   = 8'h00;

    // Field decoding
    localparam logic [6:0]  ALT_ZERO_CODE   = 7'h49;   // 73 and above
    localparam logic [7:0]  ALT_COARSE_DB   = 8'h80;   // 128 dB down
    localparam logic [7:0]  ALT_COARSE_MASK = 8'hF8;
    localparam logic [7:0]  ALT_LEVEL_ZERO  = 8'hFF;   // Measured level exactly zero

    typedef enum logic [1:0] {
        ALT_CTRL_SAT1 = 2'b00,
        ALT_CTRL_SAT2 = 2'b01,
        ALT_CTRL_MONO = 2'b10
    } alt_ctrl_t;
endpackage

// *** verilog/alt_thr_if.sv ***
// Purpose: Threshold set and level carried to one gain controller's comparator
// Assumes: Single clock domain
// Notes:   Levels are dB below full scale, 1 dB per code
`timescale 1ns/1ps
`default_nettype none
interface alt_thr_if;
    import alt_pkg::*;
    logic [ALT_FIELD_W-1:0] high_field;
    logic [ALT_FIELD_W-1:0] low_field;
    logic [ALT_FIELD_W-1:0] noise_field;
    logic [ALT_LEVEL_W-1:0] level;
    logic                   above_high;
    logic                   below_low;
    logic                   below_noise;

    modport bank (
        output high_field, low_field, noise_field, level,
        input  above_high, below_low, below_noise
    );
    modport cmp (
        input  high_field, low_field, noise_field, level,
        output above_high, below_low, below_noise
    );
endinterface
`default_nettype wire

// *** verilog/alt_level_compare.sv ***
// Purpose: Decode threshold fields and compare one controller's level
// Assumes: Level input is already in the clock domain
// Notes:   Combinational; the bank registers the results
`timescale 1ns/1ps
`default_nettype none
module alt_level_compare
    import alt_pkg::*;
(
    alt_thr_if.cmp t
);
    // Field N means 2N dB down; codes from 73 up mean zero amplitude
    function automatic logic [ALT_LEVEL_W:0] alt_decode(input logic [ALT_FIELD_W-1:0] n);
        logic [ALT_LEVEL_W:0] r;
        r = '0;
        if (n >= ALT_ZERO_CODE) begin
            r = {1'b1, ALT_LEVEL_ZERO};
        end else begin
            r = {1'b0, n, 1'b0};
        end
        return r;
    endfunction

    // Deep levels compared in 8 dB bins; saves exact matching where unneeded
    function automatic logic [ALT_LEVEL_W-1:0] alt_coarse(input logic [ALT_LEVEL_W-1:0] d);
        return (d > ALT_COARSE_DB) ? (d & ALT_COARSE_MASK) : d;
    endfunction

    logic [ALT_LEVEL_W:0]   hi_d;
    logic [ALT_LEVEL_W:0]   lo_d;
    logic [ALT_LEVEL_W:0]   no_d;
    logic                   lvl_zero;
    logic [ALT_LEVEL_W-1:0] lvl_c;

    assign hi_d     = alt_decode(t.high_field);
    assign lo_d     = alt_decode(t.low_field);
    assign no_d     = alt_decode(t.noise_field);
    assign lvl_zero = (t.level == ALT_LEVEL_ZERO);
    assign lvl_c    = alt_coarse(t.level);

    // Louder means fewer dB down; a zero threshold is exceeded by any signal
    assign t.above_high  = hi_d[ALT_LEVEL_W] ? !lvl_zero
                         : (lvl_c < alt_coarse(hi_d[ALT_LEVEL_W-1:0]));
    assign t.below_low   = lo_d[ALT_LEVEL_W] ? 1'b0
                         : (lvl_c > alt_coarse(lo_d[ALT_LEVEL_W-1:0]));
    assign t.below_noise = no_d[ALT_LEVEL_W] ? 1'b0
                         : (lvl_c > alt_coarse(no_d[ALT_LEVEL_W-1:0]));
endmodule // alt_level_compare
`default_nettype wire

// *** verification/alt_threshold_regs_asserts.sv ***
// Purpose: Port assertions for the threshold register bank
// Assumes: One clock, asynchronous active-high reset
// Notes:   Bound to alt_threshold_regs
`timescale 1ns/1ps
`default_nettype none
module alt_threshold_regs_asserts
    import alt_pkg::*;
(
    // Clock, reset, configuration port
    input wire logic       i_clk_sys,
    input wire logic       i_rst,
    input wire logic       i_ce,
    input wire logic       i_wr_en,
    input wire logic       i_rd_en,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic [7:0] o_rd_data,
    input wire logic       o_rd_valid,
    // Levels and decisions
    input wire logic [6:0] i_satellite_high_level_field,
    input wire logic [7:0] i_sat1_level,
    input wire logic [7:0] i_sat2_level,
    input wire logic [7:0] i_mono_level,
    input wire logic [2:0] o_gain_down,
    input wire logic [2:0] o_below_low,
    input wire logic [2:0] o_below_noise
);
    logic hit;
    assign hit = i_addr inside {ALT_SAT_LOW_OFS, ALT_SAT_NOISE_OFS, ALT_MONO_LOW_OFS,
                                ALT_MONO_NOISE_OFS};

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    property p_rd_valid; i_ce && i_rd_en |=> o_rd_valid; endproperty
    a_rd_valid: assert property (p_rd_valid) else $error("read without valid");
    property p_rd_idle; i_ce && !i_rd_en |=> !o_rd_valid; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("valid without read");
    property p_rsvd; o_rd_valid |-> !o_rd_data[7]; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
    property p_unmapped; i_ce && i_rd_en && !hit |=> o_rd_data == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    property p_wr_rd;
        i_ce && i_wr_en && i_addr == ALT_SAT_LOW_OFS ##1 !i_wr_en
        ##1 i_ce && i_rd_en && i_addr == ALT_SAT_LOW_OFS
        |=> o_rd_data == ($past(i_wr_data, 3) & 8'h7F);
    endproperty
    a_wr_rd: assert property (p_wr_rd) else $error("read back mismatch");
    property p_gd_on; i_ce && i_satellite_high_level_field <= 7'h40
        && i_sat1_level < {i_satellite_high_level_field, 1'b0} |=> o_gain_down[0]; endproperty
    a_gd_on: assert property (p_gd_on) else $error("gain not lowered");
    property p_gd_zero; i_ce && i_mono_level == ALT_LEVEL_ZERO |=> !o_gain_down[2]; endproperty
    a_gd_zero: assert property (p_gd_zero) else $error("gain lowered at zero level");
    property p_share; i_ce && i_sat1_level == i_sat2_level |=> o_gain_down[0] == o_gain_down[1]
        && o_below_low[0] == o_below_low[1] && o_below_noise[0] == o_below_noise[1]; endproperty
    a_share: assert property (p_share) else $error("satellite controllers differ");
    property p_ce_hold; !i_ce |=> $stable(o_rd_valid) && $stable(o_gain_down); endproperty
    a_ce_hold: assert property (p_ce_hold) else $error("state moved while disabled");
endmodule // alt_threshold_regs_asserts

bind alt_threshold_regs alt_threshold_regs_asserts i_asserts (.i_clk_sys(i_clk_sys),
    .i_rst(i_rst), .i_ce(i_ce), .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr),
    .i_wr_data(i_wr_data), .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .i_satellite_high_level_field(i_satellite_high_level_field), .i_sat1_level(i_sat1_level),
    .i_sat2_level(i_sat2_level), .i_mono_level(i_mono_level), .o_gain_down(o_gain_down),
    .o_below_low(o_below_low), .o_below_noise(o_below_noise));
`default_nettype wire

// *** verification/alt_threshold_regs_bench.sv ***
// Purpose: Self-checking bench for the threshold register bank
// Assumes: 200 MHz clock, reset held 16 cycles
// Notes:   Levels and thresholds are dB below full scale
`timescale 1ns/1ps
`default_nettype none
module alt_threshold_regs_bench;
    import alt_pkg::*;
    logic       i_clk_sys, sat_bad, mono_bad, o_rd_valid;
    logic       i_rst = 1'b1, i_ce = 1'b1, i_wr_en = 1'b0, i_rd_en = 1'b0;
    logic [7:0] i_addr = 8'h00, i_wr_data = 8'h00, lv1 = 8'h00, lv2 = 8'h00, lvm = 8'h00;
    logic [7:0] o_rd_data;
    logic [6:0] hi_s = 7'd13, hi_m = 7'd20;
    logic [2:0] gd, bl, bn;
    logic [7:0] ofs [4] = '{ALT_SAT_LOW_OFS, ALT_SAT_NOISE_OFS, ALT_MONO_LOW_OFS, ALT_MONO_NOISE_OFS};
    int         num_errors = 0, num_checks = 0, cyc = 0;

    alt_threshold_regs i_alt_threshold_regs (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce),
        .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wr_data(i_wr_data),
        .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .i_satellite_high_level_field(hi_s),
        .i_mono_high_level_field(hi_m), .i_sat1_level(lv1), .i_sat2_level(lv2),
        .i_mono_level(lvm), .o_gain_down(gd), .o_below_low(bl), .o_below_noise(bn),
        .o_sat_order_bad(sat_bad), .o_mono_order_bad(mono_bad));

    initial begin
        i_clk_sys = 1'b0;
        forever #2.5 i_clk_sys = ~i_clk_sys;
    end

    task automatic stop_test();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Tests need about 110 cycles
    always @(posedge i_clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            num_errors++;
            stop_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_wr_en   <= 1'b1;
        i_addr    <= a;
        i_wr_data <= d;
        @(posedge i_clk_sys);
        i_wr_en   <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk_sys);
        i_rd_en <= 1'b1;
        i_addr  <= a;
        @(posedge i_clk_sys);
        i_rd_en <= 1'b0;
        #1;
        chk({7'h00, o_rd_valid}, 8'h01);
        chk(o_rd_data, exp);
    endtask

    // Levels land one edge later, decisions one more
    task automatic lev(input logic [7:0] a, b, m, input logic [2:0] g, l, n);
        @(posedge i_clk_sys);
        lv1 <= a;
        lv2 <= b;
        lvm <= m;
        repeat (2) @(posedge i_clk_sys);
        #1;
        chk({5'h00, gd}, {5'h00, g});
        chk({5'h00, bl}, {5'h00, l});
        chk({5'h00, bn}, {5'h00, n});
    endtask

    task automatic t_reset();
        for (int i = 0; i < 4; i++) rd(ofs[i], 8'h00);
        $display("test reset done");
    endtask

    task automatic t_regs();
        for (int i = 0; i < 4; i++) begin
            wr(ofs[i], 8'hFF);
            rd(ofs[i], 8'h7F);
            wr(ofs[i], 8'h2A + 8'(i));
            rd(ofs[i], 8'h2A + 8'(i));
        end
        wr(8'h1A, 8'h55);
        rd(8'h1A, 8'h00);
        @(posedge i_clk_sys);
        i_ce <= 1'b0;
        wr(ofs[0], 8'h11);
        i_ce <= 1'b1;
        rd(ofs[0], 8'h2A);
        $display("test regs done");
    endtask

    task automatic t_decode();
        wr(ALT_SAT_LOW_OFS, 8'h18);
        wr(ALT_SAT_NOISE_OFS, 8'h28);
        wr(ALT_MONO_LOW_OFS, 8'h44);
        wr(ALT_MONO_NOISE_OFS, 8'h44);
        lev(8'd10, 8'd50, 8'h8F, 3'b001, 3'b010, 3'b000);
        lev(8'd48, 8'd81, 8'h90, 3'b000, 3'b110, 3'b110);
        lev(8'd26, 8'd25, 8'hFF, 3'b010, 3'b100, 3'b100);
        wr(ALT_MONO_LOW_OFS, 8'h49);
        wr(ALT_MONO_NOISE_OFS, 8'h7F);
        lev(8'd26, 8'd25, 8'hFF, 3'b010, 3'b000, 3'b000);
        wr(ALT_SAT_NOISE_OFS, 8'h48);
        lev(8'hFF, 8'd26, 8'hFF, 3'b000, 3'b001, 3'b001);
        wr(ALT_SAT_NOISE_OFS, 8'h49);
        lev(8'hFF, 8'd26, 8'hFF, 3'b000, 3'b001, 3'b000);
        $display("test decode done");
    endtask

    // High inputs moved; order flags seen both ways
    task automatic t_high();
        @(posedge i_clk_sys);
        hi_s <= 7'h14;
        hi_m <= ALT_ZERO_CODE;
        lev(8'h27, 8'h28, 8'hFE, 3'b101, 3'b000, 3'b000);
        chk({6'h00, sat_bad, mono_bad}, 8'h00);
        lev(8'h27, 8'h28, 8'hFF, 3'b001, 3'b000, 3'b000);
        // Order broken on purpose; only the flags are judged here
        @(posedge i_clk_sys);
        hi_s <= 7'h1E;
        wr(ALT_MONO_NOISE_OFS, 8'h10);
        @(posedge i_clk_sys);
        #1;
        chk({6'h00, sat_bad, mono_bad}, 8'h03);
        $display("test high done");
    endtask

    initial begin
        repeat (16) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        t_reset();
        t_regs();
        t_decode();
        t_high();
        stop_test();
    end
endmodule // alt_threshold_regs_bench
`default_nettype wire
